// file: dv/bpcl_assertions.sv
`timescale 1ns/1ps
module bpcl_assertions import bpcl_pkg::*; (
	input wire logic config_clock,
	input wire logic link_reset,
	input wire logic mode_select_msb,
	input wire logic mode_select_mid,
	input wire logic mode_select_lsb,
	input wire logic write_strobe_n,
	input wire logic read_select_n,
	input wire logic [7:0] dev_byte,
	input wire logic dev_byte_oe,
	input wire logic ready_out,
	input wire logic ready_oe,
	input wire logic ready_busy,
	input wire logic init_status
);
	// mode decode from the pins, msb first
	logic sync_on;
	logic async_on;
	assign sync_on = {mode_select_msb, mode_select_mid, mode_select_lsb} == MODE_SYNC;
	assign async_on = {mode_select_msb, mode_select_mid, mode_select_lsb} == MODE_ASYNC;

	default clocking cb @(posedge config_clock); endclocking
	default disable iff (link_reset);

	// ack: high one period, then low
	sequence ack_pulse_s;
		ready_out ##1 !ready_out;
	endsequence
	// shortest busy: two periods low
	sequence busy_min_s;
		!ready_out ##1 !ready_out;
	endsequence

	pullup_idle_a: assert property (!init_status |-> !ready_oe && ready_busy)
		else $error("handshake driven before init");
	sync_first_a: assert property (sync_on && $rose(init_status) |=> ##1 ack_pulse_s)
		else $error("first sync byte not taken on second edge");
	sync_ack_a: assert property (sync_on && $rose(ready_out) |-> init_status && ready_busy)
		else $error("sync ack not visible on the pin");
	ack_gap_a: assert property (sync_on && init_status && $rose(ready_out) |=> !ready_out [*7])
		else $error("sync capture closer than eight edges");
	write_ack_a: assert property (async_on && init_status && $rose(write_strobe_n) |-> ##[1:4] !ready_out)
		else $error("no busy after write end");
	busy_len_a: assert property (async_on && ready_oe && $fell(ready_out) |-> busy_min_s ##[1:8] ready_out)
		else $error("busy length outside two to nine periods");
	hold_write_a: assert property (async_on && $rose(write_strobe_n) |-> $past(ready_busy, 1) && $past(ready_busy, 2))
		else $error("write ended before ready held a period");
	status_off_a: assert property (read_select_n && $past(read_select_n) |-> !dev_byte_oe)
		else $error("data bus driven outside status read");
	status_value_a: assert property (dev_byte_oe |-> dev_byte[6:0] == STATUS_LOW_BITS)
		else $error("status low bits not high");
endmodule : bpcl_assertions

// file: dv/test_byte_peripheral_config_loader.sv
`timescale 1ns/1ps
module test_byte_peripheral_config_loader import bpcl_pkg::*; ();
	logic clk; // system clock
	logic srst = 1'h1; // host reset
	logic [2:0] mode_select = MODE_SYNC;
	logic byte_valid = 1'h0;
	logic [7:0] byte_data = 8'h00;
	logic byte_last = 1'h0;
	logic init_status = 1'h0; // device init done
	logic last_byte = 1'h0; // final byte marker to device
	logic byte_ready, done, cfg_bit, cfg_bit_valid, sync_mode, async_mode, parked;
	int failures = 0;
	int comparisons = 0;
	logic [7:0] sent[$]; // bytes handed to host
	logic bits[$]; // chain bits as next device sees them
	logic chain_ok = 1'h0; // chain holds a bit
	int edge_n = 0; // link rises since init
	int first_edge = 0; // rise of first chain bit

	bpcl_link_if i_bpcl_link_if();
	bpcl_host i_bpcl_host(.clk(clk), .srst(srst), .mode_select(mode_select),
		.byte_valid(byte_valid), .byte_data(byte_data), .byte_last(byte_last),
		.byte_ready(byte_ready), .done(done), .link(i_bpcl_link_if.host));
	bpcl_device i_bpcl_device(.link(i_bpcl_link_if.dev), .init_status(init_status),
		.last_byte(last_byte), .cfg_bit(cfg_bit), .cfg_bit_valid(cfg_bit_valid),
		.sync_mode(sync_mode), .async_mode(async_mode), .parked(parked));
	bpcl_assertions i_bpcl_assertions(.config_clock(i_bpcl_link_if.config_clock),
		.link_reset(i_bpcl_link_if.link_reset), .mode_select_msb(i_bpcl_link_if.mode_select_msb),
		.mode_select_mid(i_bpcl_link_if.mode_select_mid),
		.mode_select_lsb(i_bpcl_link_if.mode_select_lsb),
		.write_strobe_n(i_bpcl_link_if.write_strobe_n),
		.read_select_n(i_bpcl_link_if.read_select_n), .dev_byte(i_bpcl_link_if.dev_byte),
		.dev_byte_oe(i_bpcl_link_if.dev_byte_oe), .ready_out(i_bpcl_link_if.ready_out),
		.ready_oe(i_bpcl_link_if.ready_oe), .ready_busy(i_bpcl_link_if.ready_busy),
		.init_status(i_bpcl_link_if.init_status));

	// clock generator
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// chain bit present after falling edge
	always @(negedge i_bpcl_link_if.config_clock) chain_ok <= cfg_bit_valid;

	// sample chain on rising edge, as a chained device would
	always @(posedge i_bpcl_link_if.config_clock) begin
		edge_n = init_status ? edge_n + 1 : 0;
		if (chain_ok) begin
			if (bits.size() == 0) first_edge = edge_n;
			bits.push_back(i_bpcl_link_if.chain_out);
		end
	end

	// compare and count
	task check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// reset both ends in a mode, then release init
	task start(input logic [2:0] mode);
		@(negedge clk);
		srst = 1'h1;
		init_status = 1'h0;
		last_byte = 1'h0;
		mode_select = mode;
		repeat (20) @(negedge clk);
		srst = 1'h0;
		repeat (200) @(negedge clk);
		check({7'h00, i_bpcl_link_if.ready_busy}, 8'h01);
		check({6'h00, sync_mode, async_mode}, {6'h00, mode == MODE_SYNC, mode == MODE_ASYNC});
		bits.delete();
		sent.delete();
		init_status = 1'h1;
	endtask : start

	// hand one byte to the host user port
	task send_byte(input logic [7:0] d, input logic l);
		int n;
		byte_valid = 1'h1;
		byte_data = d;
		byte_last = l;
		n = 0;
		while (byte_ready !== 1'h1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		byte_valid = 1'h0;
		check(8'(n < 5000), 8'h01);
		sent.push_back(d);
	endtask : send_byte

	// bounded wait for the host to finish
	task wait_done();
		int n;
		n = 0;
		while (done !== 1'h1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		check(8'(n < 20000), 8'h01);
		repeat (20) @(negedge clk);
	endtask : wait_done

	// chain bits against sent bytes, lsb first
	task cmp_bits(input int count);
		check(8'(bits.size() >= count), 8'h01);
		for (int i = 0; i < count && i < bits.size(); i++) begin
			check({7'h00, bits[i]}, {7'h00, sent[i / 8][i % 8]});
		end
	endtask : cmp_bits

	// unsupported mode decodes to neither
	task mode_none_run();
		start(3'h7);
	endtask : mode_none_run

	// three sync bytes back to back, then tail
	task sync_run();
		start(MODE_SYNC);
		send_byte(8'hA5, 1'h0);
		send_byte(8'h3C, 1'h0);
		send_byte(8'h81, 1'h1);
		wait_done();
		check(8'(first_edge), 8'h04);
		check(8'(edge_n), 8'(2 + 8 * 2 + int'(TAIL_COUNT)));
		check({7'h00, i_bpcl_link_if.config_clock}, 8'h01);
		cmp_bits(24);
	endtask : sync_run

	// three async writes, final one parks at bit 6
	task async_run();
		int n;
		start(MODE_ASYNC);
		send_byte(8'h96, 1'h0);
		send_byte(8'h5A, 1'h0);
		send_byte(8'h43, 1'h1);
		n = 0;
		while (i_bpcl_link_if.write_strobe_n !== 1'h0 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		while (i_bpcl_link_if.write_strobe_n !== 1'h1 && n < 10000) begin
			@(negedge clk);
			n++;
		end
		check(8'(n < 10000), 8'h01);
		last_byte = 1'h1;
		wait_done();
		check({7'h00, parked}, 8'h01);
		check({7'h00, i_bpcl_link_if.chain_out}, 8'h01);
		check({7'h00, i_bpcl_link_if.config_clock}, 8'h01);
		cmp_bits(23);
	endtask : async_run

	// counts, verdict, end of run
	task stop_test();
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// main sequence
	initial begin
		mode_none_run();
		sync_run();
		async_run();
		stop_test();
	end

	// watchdog well beyond the expected run
	initial begin
		#600000;
		failures++;
		$display("Error at %0t: watchdog expired", $time);
		stop_test();
	end
endmodule : test_byte_peripheral_config_loader

// file: logic/bpcl_device.sv
// Operation
// - mode pins 011 select synchronous mode
// - first sync byte on second edge after init
// - later sync bytes every eighth edge
// - sync ack high one period at capture
// - handshake undriven, pulled high before init
// - chain output 1.5 periods later, falling edges
// - source gives 10 plus chain-length edges after
// - mode pins 101 select asynchronous mode
// - async byte latched at write condition end
// - input buffer feeds parallel-to-serial shifter
// - async busy on receipt until buffer moves
// - host may start next write once busy
// - host holds write until ready one period
// - busy two periods empty, up to nine
// - final async byte: seven bits, hold bit 6
// - handshake optional if writes over 10 periods
// - status read: top bit ready, rest high
// - shifting paced by own clock, after previous
// - host completes startup within one byte write
// - host waits for init before configuring
`timescale 1ns/1ps
module bpcl_device import bpcl_pkg::*; (
	bpcl_link_if.dev link,
	input wire logic init_status,
	input wire logic last_byte,
	output logic cfg_bit,
	output logic cfg_bit_valid,
	output logic sync_mode,
	output logic async_mode,
	output logic parked
);
	// pin synchronisers
	logic [14:0] pin_meta;
	logic [14:0] pin_sync;
	logic rst_meta;
	logic rst;
	// decoded synchronised pins
	logic [2:0] mode_now;
	logic ws_n;
	logic rsel_n;
	logic sel_low;
	logic sel_high;
	logic [7:0] bus_sync;
	// async write detect
	logic write_cond;
	logic write_prev;
	logic write_end;
	logic read_cond;
	logic [7:0] write_hold;
	// sync capture sequencing
	logic sync_armed;
	logic sync_started;
	logic [2:0] sync_cnt;
	logic capture_sync;
	// double buffer and shifter
	logic [7:0] buf_byte;
	logic buf_full;
	logic [7:0] sh_data;
	logic [3:0] sh_cnt;
	logic final_loaded;
	logic load_shift;
	// pin outputs
	logic ready;
	logic status_oe;
	logic [7:0] status_byte;
	logic chain_bit;

	// two flops on every pin from the host
	always_ff @(posedge link.config_clock) begin
		pin_meta <= {link.mode_select_msb, link.mode_select_mid, link.mode_select_lsb,
			link.write_strobe_n, link.read_select_n, link.select_active_low,
			link.select_active_high, link.config_byte_bus};
		pin_sync <= pin_meta;
	end

	// link reset synchroniser
	always_ff @(posedge link.config_clock) begin
		rst_meta <= link.link_reset;
		rst <= rst_meta;
	end

	assign mode_now = pin_sync[14:12];
	assign ws_n = pin_sync[11];
	assign rsel_n = pin_sync[10];
	assign sel_low = pin_sync[9];
	assign sel_high = pin_sync[8];
	assign bus_sync = pin_sync[7:0];

	// mode decode, registered
	always_ff @(posedge link.config_clock) begin
		if (rst) begin
			sync_mode <= 1'b0;
			async_mode <= 1'b0;
		end else begin
			sync_mode <= (mode_now == MODE_SYNC);
			async_mode <= (mode_now == MODE_ASYNC);
		end
	end

	// write and read select conditions
	assign write_cond = async_mode & ~ws_n & ~sel_low & rsel_n & sel_high;
	assign read_cond = async_mode & ~sel_low & sel_high & ~rsel_n;
	assign write_end = write_prev & ~write_cond;

	// track write condition, keep byte seen while active
	always_ff @(posedge link.config_clock) begin
		if (rst) begin
			write_prev <= 1'b0;
			write_hold <= BYTE_RESET;
		end else begin
			write_prev <= write_cond;
			if (write_cond) begin
				write_hold <= bus_sync;
			end
		end
	end

	// sync mode: second edge after init, then every eighth
	assign capture_sync = sync_mode & init_status & sync_armed
		& (~sync_started | (sync_cnt == SYNC_LAST_CNT));

	// edge counting for sync captures
	always_ff @(posedge link.config_clock) begin
		if (rst || !sync_mode || !init_status) begin
			sync_armed <= 1'b0;
			sync_started <= 1'b0;
			sync_cnt <= 3'h0;
		end else begin
			sync_armed <= 1'b1;
			if (capture_sync) begin
				sync_started <= 1'b1;
				sync_cnt <= 3'h0;
			end else begin
				sync_cnt <= sync_cnt + 3'h1;
			end
		end
	end

	// buffer moves to shifter when its last bit is out
	assign load_shift = buf_full & (sh_cnt <= SHIFT_ONE) & ~parked;

	// input byte register; a new byte wins over the move
	always_ff @(posedge link.config_clock) begin
		if (rst) begin
			buf_full <= 1'b0;
			buf_byte <= BYTE_RESET;
		end else if (capture_sync) begin
			buf_full <= 1'b1;
			buf_byte <= link.config_byte_bus;
		end else if (write_end) begin
			buf_full <= 1'b1;
			buf_byte <= write_hold;
		end else if (load_shift) begin
			buf_full <= 1'b0;
		end
	end

	// parallel-to-serial shifter, lsb first
	always_ff @(posedge link.config_clock) begin
		if (rst) begin
			sh_data <= BYTE_RESET;
			sh_cnt <= SHIFT_EMPTY;
			final_loaded <= 1'b0;
			parked <= 1'b0;
		end else if (load_shift) begin
			sh_data <= buf_byte;
			// final async byte sends only seven bits
			if (async_mode && last_byte) begin
				sh_cnt <= SHIFT_FINAL;
				final_loaded <= 1'b1;
			end else begin
				sh_cnt <= SHIFT_FULL;
				final_loaded <= 1'b0;
			end
		end else if (sh_cnt > SHIFT_ONE) begin
			sh_data <= {1'b0, sh_data[7:1]};
			sh_cnt <= sh_cnt - SHIFT_ONE;
		end else if (sh_cnt == SHIFT_ONE) begin
			// last bit stays put, chain output holds it
			sh_cnt <= SHIFT_EMPTY;
			if (final_loaded) begin
				parked <= 1'b1;
			end
		end
	end

	assign cfg_bit = sh_data[0];
	assign cfg_bit_valid = (sh_cnt != SHIFT_EMPTY);

	// handshake: ack pulse in sync, ready/busy in async
	always_ff @(posedge link.config_clock) begin
		if (rst) begin
			ready <= READY_RESET;
		end else if (sync_mode) begin
			ready <= capture_sync;
		end else if (async_mode) begin
			// low from receipt until one edge after the move
			ready <= ~(write_end | buf_full);
		end else begin
			ready <= READY_RESET;
		end
	end

	// status read drive, bus free otherwise
	always_ff @(posedge link.config_clock) begin
		if (rst) begin
			status_oe <= 1'b0;
			status_byte <= BUS_IDLE;
		end else begin
			status_oe <= read_cond;
			status_byte <= {ready, STATUS_LOW_BITS};
		end
	end

	// chain bit moves on falling edge, half period after shift
	always_ff @(negedge link.config_clock) begin
		if (rst) begin
			chain_bit <= 1'b0;
		end else begin
			chain_bit <= sh_data[0];
		end
	end

	// pin drives
	assign link.ready_out = ready;
	assign link.ready_oe = init_status;
	assign link.dev_byte = status_byte;
	assign link.dev_byte_oe = status_oe;
	assign link.chain_out = chain_bit;
	assign link.init_status = init_status;
endmodule : bpcl_device

// file: logic/bpcl_host.sv
`timescale 1ns/1ps
module bpcl_host import bpcl_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic [2:0] mode_select,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic byte_last,
	output logic byte_ready,
	output logic done,
	bpcl_link_if.host link
);
	typedef enum logic [2:0] {
		H_RESET, H_WAIT_INIT, H_SYNC_RUN, H_SYNC_TAIL,
		H_ASYNC_IDLE, H_ASYNC_WRITE, H_ASYNC_ACK, H_DONE
	} bpcl_host_state_t;
	bpcl_host_state_t state;
	logic [3:0] half_cnt; // divider phase
	logic lclk; // link clock
	logic run; // clock may leave its high rest
	logic tick;
	logic rise;
	logic [3:0] rst_cnt; // link reset edges
	logic [2:0] mode_q;
	logic rdy_meta;
	logic rdy_s;
	logic rdy_prev;
	logic init_meta;
	logic init_s;
	logic ack_rise;
	logic have_byte;
	logic cur_last;
	logic [7:0] out_byte;
	logic wr_n;
	logic [4:0] tail_cnt;
	logic [4:0] hold_cnt;
	logic take;

	// clock runs in reset, with a byte, in tail and in async
	assign run = (state == H_RESET) | (state == H_SYNC_TAIL) | ((state == H_SYNC_RUN) & have_byte)
		| (state == H_ASYNC_IDLE) | (state == H_ASYNC_WRITE) | (state == H_ASYNC_ACK);
	assign tick = (half_cnt == LINK_HALF_LAST);
	assign rise = tick & ~lclk & run;

	// divider, stops only in high phase
	always_ff @(posedge clk) begin
		if (srst) begin
			half_cnt <= 4'h0;
			lclk <= 1'b0;
		end else if (run || !lclk) begin
			if (tick) begin
				half_cnt <= 4'h0;
				lclk <= ~lclk;
			end else begin
				half_cnt <= half_cnt + 4'h1;
			end
		end
	end

	// device pins into clk domain
	always_ff @(posedge clk) begin
		rdy_meta <= link.ready_busy;
		rdy_s <= rdy_meta;
		init_meta <= link.init_status;
		init_s <= init_meta;
		rdy_prev <= rdy_s;
	end
	assign ack_rise = rdy_s & ~rdy_prev;

	assign byte_ready = ((state == H_SYNC_RUN) & ~have_byte) | (state == H_ASYNC_IDLE);
	assign take = byte_valid & byte_ready;

	// sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= H_RESET;
			rst_cnt <= 4'h0;
			mode_q <= 3'h0;
			have_byte <= 1'b0;
			cur_last <= 1'b0;
			out_byte <= BYTE_RESET;
			wr_n <= 1'b1;
			tail_cnt <= 5'h0;
			hold_cnt <= 5'h0;
			done <= 1'b0;
		end else begin
			if (take) begin
				out_byte <= byte_data;
				cur_last <= byte_last;
			end
			unique case (state)
				H_RESET: begin
					mode_q <= mode_select;
					if (rise) begin
						rst_cnt <= rst_cnt + 4'h1;
					end
					// keep clocking after reset drops so the device sees it released
					if (rst_cnt == LINK_RESET_EDGES + LINK_RUN_EDGES) begin
						state <= H_WAIT_INIT;
					end
				end
				H_WAIT_INIT: begin
					// nothing starts before init is high
					if (init_s) begin
						if (mode_q == MODE_SYNC) begin
							state <= H_SYNC_RUN;
						end else if (mode_q == MODE_ASYNC) begin
							state <= H_ASYNC_IDLE;
						end
					end
				end
				H_SYNC_RUN: begin
					// ack marks capture; next byte before eighth edge
					if (take) begin
						have_byte <= 1'b1;
					end else if (have_byte && ack_rise) begin
						have_byte <= 1'b0;
						if (cur_last) begin
							state <= H_SYNC_TAIL;
						end
					end
				end
				H_SYNC_TAIL: begin
					// extra edges to finish the serial shift
					if (rise) begin
						tail_cnt <= tail_cnt + 5'h1;
					end
					if (tail_cnt == TAIL_COUNT) begin
						state <= H_DONE;
					end
				end
				H_ASYNC_IDLE: begin
					// one complete write per byte; may start while busy
					if (take) begin
						wr_n <= 1'b0;
						hold_cnt <= 5'h0;
						state <= H_ASYNC_WRITE;
					end
				end
				H_ASYNC_WRITE: begin
					// end write only after ready high three full link periods
					if (!rdy_s) begin
						hold_cnt <= 5'h0;
					end else if (hold_cnt == ASYNC_HOLD_CYC) begin
						wr_n <= 1'b1;
						state <= H_ASYNC_ACK;
					end else begin
						hold_cnt <= hold_cnt + 5'h1;
					end
				end
				H_ASYNC_ACK: begin
					// busy shows the byte was taken; last byte still needs clocks to shift
					if (!rdy_s) begin
						state <= cur_last ? H_SYNC_TAIL : H_ASYNC_IDLE;
					end
				end
				H_DONE: begin
					done <= 1'b1;
				end
			endcase
		end
	end

	// pin drives
	assign link.config_clock = lclk;
	// reset only over the first edges of the reset phase
	assign link.link_reset = (state == H_RESET) & (rst_cnt < LINK_RESET_EDGES);
	assign link.mode_select_msb = mode_q[2];
	assign link.mode_select_mid = mode_q[1];
	assign link.mode_select_lsb = mode_q[0];
	assign link.write_strobe_n = wr_n;
	assign link.select_active_low = wr_n;
	assign link.select_active_high = 1'b1;
	assign link.read_select_n = 1'b1;
	assign link.host_byte = out_byte;
	assign link.host_byte_oe = ((state == H_SYNC_RUN) & have_byte) | ~wr_n;
endmodule : bpcl_host

// file: logic/bpcl_link_if.sv
`timescale 1ns/1ps
interface bpcl_link_if import bpcl_pkg::*; ();
	logic config_clock; // link clock, made by host
	logic link_reset; // host-made reset, link side
	logic mode_select_msb;
	logic mode_select_mid;
	logic mode_select_lsb;
	logic write_strobe_n;
	logic read_select_n;
	logic select_active_low;
	logic select_active_high;
	logic [7:0] host_byte; // host drive of data bus
	logic host_byte_oe;
	logic [7:0] dev_byte; // device drive of data bus
	logic dev_byte_oe;
	logic [7:0] config_byte_bus; // resolved bus
	logic ready_out; // device drive of ready/busy
	logic ready_oe;
	logic ready_busy; // resolved pin, weak pull-up
	logic chain_out; // daisy-chain serial out
	logic init_status;

	// bus resolution, idle lines pulled high
	assign config_byte_bus = host_byte_oe ? host_byte : (dev_byte_oe ? dev_byte : BUS_IDLE);
	assign ready_busy = ready_oe ? ready_out : 1'b1;

	modport dev (
		input config_clock, link_reset, mode_select_msb, mode_select_mid, mode_select_lsb,
		input write_strobe_n, read_select_n, select_active_low, select_active_high,
		input config_byte_bus,
		output dev_byte, dev_byte_oe, ready_out, ready_oe, chain_out, init_status
	);
	modport host (
		output config_clock, link_reset, mode_select_msb, mode_select_mid, mode_select_lsb,
		output write_strobe_n, read_select_n, select_active_low, select_active_high,
		output host_byte, host_byte_oe,
		input config_byte_bus, ready_busy, chain_out, init_status
	);
endinterface : bpcl_link_if

// file: logic/bpcl_pkg.sv
package bpcl_pkg;
	// mode pin codes, msb first
	localparam logic [2:0] MODE_SYNC = 3'h3;
	localparam logic [2:0] MODE_ASYNC = 3'h5;
	// clock rates
	localparam int CLK_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 40;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [3:0] LINK_HALF_LAST = 4'(LINK_HALF_CYC - 1);
	// link reset length in link rising edges
	localparam logic [3:0] LINK_RESET_EDGES = 4'h8;
	// link rises after reset drops, so the device leaves reset before the clock rests
	localparam logic [3:0] LINK_RUN_EDGES = 4'h4;
	// sync mode: byte every eighth edge
	localparam logic [2:0] SYNC_LAST_CNT = 3'h7;
	// shifter loads
	localparam logic [3:0] SHIFT_FULL = 4'h8;
	localparam logic [3:0] SHIFT_FINAL = 4'h7;
	localparam logic [3:0] SHIFT_EMPTY = 4'h0;
	localparam logic [3:0] SHIFT_ONE = 4'h1;
	// status byte low bits, idle bus level
	localparam logic [6:0] STATUS_LOW_BITS = 7'h7F;
	localparam logic [7:0] BUS_IDLE = 8'hFF;
	// reset values
	localparam logic READY_RESET = 1'b1;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// sync tail: 10 edges plus one per chained device
	localparam int SYNC_TAIL_EDGES = 10;
	localparam int CHAIN_DEVICES = 1;
	localparam logic [4:0] TAIL_COUNT = 5'(SYNC_TAIL_EDGES + CHAIN_DEVICES);
	// async hold: ready high for more than one link period, in clk cycles
	localparam logic [4:0] ASYNC_HOLD_CYC = 5'(3 * 2 * LINK_HALF_CYC);
endpackage : bpcl_pkg
